// [hdl/remote_port_device.sv]
// Instrument end of the run-coordination control lines
//
// Behaviour
// - Low level is true except power, ready
// - Drive only by pulling low, also sense
// - Prepare request triggers preparation work
// - Start line begins run-time activities
// - Serious fault asserts halt; halt stops activities
// - Powered line gates reliance on others (here it gates only run start and the sequencer)
// - Sequencer waits for ready line
// - Stop line ends run quickly
// - Only injector acts on injection request
// - Order is ready, start, optional stop
// - One halt line, one powered line
`timescale 1ns/1ps
module remote_port_device (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   remote_port_if.device port,
   input wire logic is_injector_in,
   input wire logic is_sequencer_in,
   input wire logic local_prep_in,
   input wire logic local_start_in,
   input wire logic local_stop_in,
   input wire logic local_inject_in,
   input wire logic local_fault_in,
   input wire logic local_busy_in,

   output logic prep_pulse_out,
   output logic run_start_pulse_out,
   output logic run_stop_pulse_out,
   output logic inject_pulse_out,
   output logic halt_out,
   output logic powered_out,
   output logic ready_out,
   output logic running_out,
   output remote_port_pkg::seq_state_e seq_state_out
);
   import remote_port_pkg::*;

   lines_t sync1_reg;
   lines_t sync2_reg;

   lines_t prev_reg;
   lines_t drive_reg;
   lines_t logic_now;
   lines_t rise;

   seq_state_e state_reg;
   logic running_reg;
   logic stop_seen_reg;

   // Halt or a fresh stop ends run-time activity at once
   function automatic logic run_ends(input lines_t now_l, input lines_t rise_l);
      run_ends = now_l[LINE_HALT] || rise_l[LINE_STOP];
   endfunction : run_ends

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         // Preset to the released level so no event follows reset
         sync1_reg <= OE_RELEASED;
         sync2_reg <= OE_RELEASED;
      end else begin
         sync1_reg <= port.line_level;
         sync2_reg <= sync1_reg;
      end
   end

   assign logic_now = to_logical(sync2_reg);
   assign rise = logic_now & ~prev_reg;

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         // Idle logical view of released lines
         prev_reg <= to_logical(OE_RELEASED);
      end else begin
         prev_reg <= logic_now;
      end
   end

   // Event pulses to the local logic
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         prep_pulse_out <= 1'b0;
         run_start_pulse_out <= 1'b0;
         run_stop_pulse_out <= 1'b0;
         inject_pulse_out <= 1'b0;
      end else begin
         prep_pulse_out <= rise[LINE_PREP];
         run_start_pulse_out <= rise[LINE_START];
         run_stop_pulse_out <= rise[LINE_STOP];
         inject_pulse_out <= rise[LINE_INJECT] & is_injector_in;
      end
   end

   // Logical levels of the summary lines
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         halt_out <= 1'b0;
         powered_out <= 1'b0;
         ready_out <= 1'b0;
      end else begin
         halt_out <= logic_now[LINE_HALT];
         powered_out <= logic_now[LINE_POWERED];
         ready_out <= logic_now[LINE_READY];
      end
   end

   // Run activity: start begins, stop or halt ends
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         running_reg <= 1'b0;
      end else if (run_ends(logic_now, rise)) begin
         running_reg <= 1'b0;
      end else if (rise[LINE_START] && logic_now[LINE_POWERED]) begin
         running_reg <= 1'b1;
      end
   end

   assign running_out = running_reg;

   // Sequencer for a controlling module
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         state_reg <= SEQ_IDLE;
      end else begin
         case (state_reg)
            SEQ_IDLE: begin
               if (is_sequencer_in && local_start_in) begin
                  state_reg <= SEQ_WAIT_READY;
               end
            end

            SEQ_WAIT_READY: begin
               if (logic_now[LINE_HALT]) begin
                  state_reg <= SEQ_IDLE;
               end else if (logic_now[LINE_READY] && logic_now[LINE_POWERED]) begin
                  state_reg <= SEQ_RUN;
               end
            end

            SEQ_RUN: begin
               if (local_stop_in || run_ends(logic_now, rise)) begin
                  state_reg <= SEQ_STOPPED;
               end
            end

            // Own stop drive ends first, so this exit cannot lock up
            SEQ_STOPPED: begin
               if (!logic_now[LINE_START] && !logic_now[LINE_STOP]) begin
                  state_reg <= SEQ_IDLE;
               end
            end

            default: begin
               state_reg <= SEQ_IDLE;
            end
         endcase
      end
   end

   assign seq_state_out = state_reg;

   // Stop is held until this end sees it with start released
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         stop_seen_reg <= 1'b0;
      end else if (state_reg != SEQ_STOPPED) begin
         stop_seen_reg <= 1'b0;
      end else if (logic_now[LINE_STOP] && !logic_now[LINE_START]) begin
         stop_seen_reg <= 1'b1;
      end
   end

   // Conditions this end asserts onto the lines
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         drive_reg <= '0;
      end else begin
         drive_reg[LINE_PREP] <= local_prep_in;
         drive_reg[LINE_START] <= state_reg == SEQ_RUN;
         drive_reg[LINE_STOP] <= (state_reg == SEQ_STOPPED) && !stop_seen_reg;
         drive_reg[LINE_INJECT] <= local_inject_in;
         drive_reg[LINE_HALT] <= local_fault_in;
         // Powered line: released means true; never pulled while on
         drive_reg[LINE_POWERED] <= 1'b0;
         // Ready is pulled low (false) while locally busy
         drive_reg[LINE_READY] <= local_busy_in;
      end
   end

   assign port.dev_pin_out = '0;
   assign port.dev_pin_oe_n = drive_oe(drive_reg);
endmodule : remote_port_device

// [hdl/remote_port_host.sv]
// Partner end of the run-coordination control lines
`timescale 1ns/1ps
module remote_port_host (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   remote_port_if.host port,
   input wire remote_port_pkg::lines_t pull_low_in,
   output remote_port_pkg::lines_t line_logical_out
);
   import remote_port_pkg::*;

   lines_t sync1_reg;
   lines_t sync2_reg;
   lines_t drive_reg;

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         sync1_reg <= OE_RELEASED;
         sync2_reg <= OE_RELEASED;
      end else begin
         sync1_reg <= port.line_level;
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         line_logical_out <= '0;
      end else begin
         line_logical_out <= to_logical(sync2_reg);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         drive_reg <= '0;
      end else begin
         drive_reg <= pull_low_in;
      end
   end

   assign port.host_pin_out = '0;
   assign port.host_pin_oe_n = drive_oe(drive_reg);
endmodule : remote_port_host

// [hdl/remote_port_if.sv]
// Shared wired-OR control lines joining the instrument and the partner end
`timescale 1ns/1ps
interface remote_port_if;
   import remote_port_pkg::*;
   // Per-end pin signals; output data is always low (open collector)
   lines_t dev_pin_out;
   lines_t dev_pin_oe_n;
   lines_t host_pin_out;
   lines_t host_pin_oe_n;
   lines_t line_level;
   // Wired-OR resolution with pull-ups
   assign line_level = (dev_pin_oe_n | dev_pin_out) & (host_pin_oe_n | host_pin_out);

   modport device (output dev_pin_out, output dev_pin_oe_n, input line_level);
   modport host (output host_pin_out, output host_pin_oe_n, input line_level);
endinterface : remote_port_if

// [hdl/remote_port_pkg.sv]
// Constants shared by both ends of the run-coordination control lines
package remote_port_pkg;
   // Line indices in the shared line vector
   localparam int LINE_PREP = 0;
   localparam int LINE_START = 1;
   localparam int LINE_HALT = 2;
   localparam int LINE_POWERED = 3;
   localparam int LINE_READY = 4;
   localparam int LINE_STOP = 5;
   localparam int LINE_INJECT = 6;
   localparam int NUM_LINES = 7;
   // Electrical level that reads as true for each line (0 = low true)
   localparam logic [NUM_LINES-1:0] TRUE_LEVEL = 7'h18;
   // Released outputs: enable high means not driving
   localparam logic [NUM_LINES-1:0] OE_RELEASED = 7'h7f;
   localparam int SYNC_STAGES = 2;

   typedef logic [NUM_LINES-1:0] lines_t;

   typedef enum logic [3:0] {
      SEQ_IDLE = 4'h1,
      SEQ_WAIT_READY = 4'h2,
      SEQ_RUN = 4'h4,
      SEQ_STOPPED = 4'h8
   } seq_state_e;

   // Logical truth of sampled pin levels
   function automatic lines_t to_logical(input lines_t level);
      to_logical = ~(level ^ TRUE_LEVEL);
   endfunction : to_logical

   // Output enable that pulls an open-collector pin low for each set mask bit
   function automatic lines_t drive_oe(input lines_t assert_mask);
      drive_oe = ~assert_mask;
   endfunction : drive_oe
endpackage : remote_port_pkg

// [tb/remote_port_props.sv]
// Concurrent checks on the shared control lines
`timescale 1ns/1ps
module remote_port_props (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire remote_port_pkg::lines_t dev_pin_out,
   input wire remote_port_pkg::lines_t dev_pin_oe_n,
   input wire remote_port_pkg::lines_t host_pin_out,
   input wire remote_port_pkg::lines_t host_pin_oe_n,
   input wire remote_port_pkg::lines_t line_level
);
   import remote_port_pkg::*;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   a_pull_low_only: assert property (dev_pin_out == '0 && host_pin_out == '0)
      else $error("pin data not low");
   a_reset_release: assert property ($rose(resetn_in) |-> &dev_pin_oe_n && &host_pin_oe_n)
      else $error("outputs driven after reset");
   a_power_undriven: assert property (dev_pin_oe_n[LINE_POWERED])
      else $error("device pulls powered line");
   a_start_needs_ready: assert property ($fell(dev_pin_oe_n[LINE_START]) |->
      $past(line_level[LINE_READY] & line_level[LINE_POWERED] & line_level[LINE_HALT], 2))
      else $error("start driven without ready");
   a_halt_ends_start: assert property (
      !line_level[LINE_HALT] [*6] |=> dev_pin_oe_n[LINE_START])
      else $error("start held during halt");
   a_stop_ends_start: assert property (
      !line_level[LINE_STOP] [*6] |=> dev_pin_oe_n[LINE_START])
      else $error("start held during stop");
   a_start_stop_excl: assert property (dev_pin_oe_n[LINE_START] | dev_pin_oe_n[LINE_STOP])
      else $error("start and stop driven together");
   a_sync_delay: assert property ($rose(line_level[LINE_READY]) && dev_pin_oe_n[LINE_START]
      |=> dev_pin_oe_n[LINE_START] [*2])
      else $error("start reacted too early");
   c_dev_start: cover property (!dev_pin_oe_n[LINE_START]);
   c_dev_stop: cover property (!dev_pin_oe_n[LINE_STOP]);
   c_host_halt: cover property (!host_pin_oe_n[LINE_HALT]);
endmodule : remote_port_props

// [tb/tb_remote_port.sv]
// Self-checking bench joining both ends of the control lines
`timescale 1ns/1ps
module tb_remote_port;
   import remote_port_pkg::*;
   logic sys_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic inj = 1'b1;
   logic seqr = 1'b0;
   logic [5:0] loc = '0;
   lines_t pull_low = '0;
   lines_t host_log;
   lines_t seen = '0;
   logic prep_p, start_p, stop_p, inj_p, halt, powered, ready, running;
   seq_state_e seq;
   int npulse = 0;
   int n_mismatch = 0;
   int total_checks = 0;
   always #5 sys_clk_in = ~sys_clk_in;
   remote_port_if port ();
   remote_port_device i_remote_port_device (.sys_clk_in, .resetn_in, .port(port.device),
      .is_injector_in(inj), .is_sequencer_in(seqr), .local_prep_in(loc[0]),
      .local_start_in(loc[1]), .local_stop_in(loc[2]), .local_inject_in(loc[3]),
      .local_fault_in(loc[4]), .local_busy_in(loc[5]), .prep_pulse_out(prep_p),
      .run_start_pulse_out(start_p), .run_stop_pulse_out(stop_p), .inject_pulse_out(inj_p),
      .halt_out(halt), .powered_out(powered), .ready_out(ready), .running_out(running),
      .seq_state_out(seq));
   remote_port_host i_remote_port_host (.sys_clk_in, .resetn_in, .port(port.host),
      .pull_low_in(pull_low), .line_logical_out(host_log));
   remote_port_props i_remote_port_props (.sys_clk_in, .resetn_in,
      .dev_pin_out(port.dev_pin_out), .dev_pin_oe_n(port.dev_pin_oe_n),
      .host_pin_out(port.host_pin_out), .host_pin_oe_n(port.host_pin_oe_n),
      .line_level(port.line_level));
   always @(posedge sys_clk_in) begin
      seen <= seen | {inj_p, stop_p, 3'h0, start_p, prep_p};
      npulse <= npulse + int'(inj_p | stop_p | start_p | prep_p);
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic hold(input int n, input lines_t pl, input logic [5:0] lc);
      @(negedge sys_clk_in);
      pull_low = pl;
      loc = lc;
      repeat (n) @(negedge sys_clk_in);
   endtask : hold
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (5000) @(posedge sys_clk_in);
      n_mismatch++;
      final_report();
   end
   initial begin
      lines_t m;
      repeat (10) @(negedge sys_clk_in);
      resetn_in = 1'b1;
      hold(6, '0, 6'h00);
      chk({1'b0, port.dev_pin_oe_n}, 8'h7f);
      chk({halt, powered, ready, running, seq}, 8'h61);
      for (int k = 0; k < 2; k++) begin
         inj = (k == 0);
         m = inj ? 7'h63 : 7'h23;
         for (int i = 0; i < 7; i++) begin
            seen = '0;
            npulse = 0;
            hold(6, lines_t'(1) << i, 6'h00);
            chk({1'b0, host_log}, {1'b0, (lines_t'(1) << i) ^ 7'h18});
            hold(6, '0, 6'h00);
            chk({1'b0, seen}, {1'b0, (lines_t'(1) << i) & m});
            chk(8'(npulse), 8'(((m >> i) & 7'h01) != 0));
         end
      end
      hold(6, 7'h08, 6'h00);
      hold(6, 7'h0a, 6'h00);
      chk(8'({powered, running}), 8'h00);
      hold(6, '0, 6'h10);
      chk({halt, host_log}, 8'h9c);
      seqr = 1'b1;
      hold(6, '0, 6'h20);
      hold(6, '0, 6'h22);
      chk(8'({ready, running, seq}), 8'h02);
      chk({1'b0, host_log}, 8'h08);
      hold(10, '0, 6'h00);
      chk(8'({ready, running, seq}), 8'h34);
      chk({1'b0, host_log}, 8'h1a);
      hold(8, 7'h04, 6'h00);
      chk(8'({running, seq}), 8'h08);
      chk({1'b0, host_log}, 8'h3c);
      hold(6, '0, 6'h00);
      chk(8'({halt, running, seq}), 8'h01);
      chk({1'b0, host_log}, 8'h18);
      final_report();
   end
endmodule : tb_remote_port
